// ### hdl/wge_bank.sv
// Wake enable gating bank: enable and status registers behind APB,
// driving the active-low wake output toward the host platform.
// Assumes presetn is the standby-supply power-on reset and that
// host_reset is a same-clock pulse for main POR, soft and bus reset.
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps

// Notes on behaviour
// RQ1: Wake output is active when a source's enable, status and the global enable are all 1.
// RQ2: A disabled source still records its wake state in status but never drives wake.
// RQ3: Enables survive main power-on, soft and bus reset and clear only on standby power-on.
// RQ4: The second enable register maps bits 0 to 7 onto first-group pins 0 to 7.
// RQ5: The third enable register maps bits 0 to 7 onto second-group pins 0 to 7.
// RQ6: The fourth register maps bits 0-3 to c0-c3, bits 4-5 to d1, d3 and bits 6-7 to e0, e1.
// RQ7: Writing 1 to a status bit clears it and writing 0 leaves it alone.
// RQ8: Each status bit is set by its own source event whatever the enable bits say.
// RQ9: Wake is the OR over all sources of enable AND status, gated by the global enable.
module wge_bank
   import wge_pkg::*;
(
   // Clock, reset and enable
   input  logic              pclk,
   input  logic              presetn,
   input  logic              clk_en,
   input  logic              host_reset,
   // APB slave
   input  logic              psel,
   input  logic              penable,
   input  logic              pwrite,
   input  logic [ADDR_W-1:0] paddr,
   input  logic [DATA_W-1:0] pwdata,
   input  logic [3:0]        pstrb,
   output logic              pready,
   output logic [DATA_W-1:0] prdata,
   output logic              pslverr,
   // Wake source pins
   input  logic [7:0]        gpio_a,
   input  logic [7:0]        gpio_b,
   input  logic [3:0]        gpio_c,
   input  logic              gpio_d1,
   input  logic              gpio_d3,
   input  logic              gpio_e0,
   input  logic              gpio_e1,
   input  logic              second_port_ring_indicate_n,
   // Outputs
   output logic              wake_output_n,
   output logic              irq
);

   typedef struct packed {
      logic [SRC_W-1:0]  en;
      logic [SRC_W-1:0]  sts;
      logic              gen;
      logic [IRQ_W-1:0]  irq_sts;
      logic [IRQ_W-1:0]  irq_en;
      logic [DATA_W-1:0] rdata;
      logic              err;
      logic              wake_n;
      logic              wake_q;
   } wge_bank_state_type;

   wge_bank_state_type r;
   wge_bank_state_type next_r;
   logic [SRC_W-1:0]   raw_pins;

   wge_src_if src_bus ();

   // Source vector in register bit order; ring indicate made active high
   assign raw_pins = {~second_port_ring_indicate_n,                  // RQ6
                      gpio_e1, gpio_e0, gpio_d3, gpio_d1, gpio_c,    // RQ6
                      gpio_b,                                        // RQ5
                      gpio_a};                                       // RQ4

   // Pin synchroniser and event detector
   wge_pin_sync u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .clk_en  (clk_en),
      .pins    (raw_pins),
      .src     (src_bus.producer)
   );

   // Bus handshake terms
   logic apb_setup;
   logic apb_acc;
   logic apb_wr;

   assign apb_setup = psel && !penable;
   assign apb_acc   = psel && penable;
   assign apb_wr    = apb_acc && pwrite && pstrb[0];

   // Address map membership, kept apart from the read decode for the checks
   function automatic logic addr_mapped(input logic [ADDR_W-1:0] addr);
      addr_mapped = reg_hit(addr, IDX_EN_RING) || reg_hit(addr, IDX_EN_G1)    ||
                    reg_hit(addr, IDX_EN_G2)   || reg_hit(addr, IDX_EN_G3)    ||
                    reg_hit(addr, IDX_STS_G1)  || reg_hit(addr, IDX_STS_G2)   ||
                    reg_hit(addr, IDX_STS_G3)  || reg_hit(addr, IDX_STS_RING) ||
                    reg_hit(addr, IDX_CTRL)    || reg_hit(addr, IDX_IRQ_STS)  ||
                    reg_hit(addr, IDX_IRQ_CLR) || reg_hit(addr, IDX_IRQ_EN);
   endfunction : addr_mapped

   // Next-state logic
   always_comb
   begin
      logic [DATA_W-1:0] rd;
      logic              miss;
      logic [SRC_W-1:0]  clr;
      logic [IRQ_W-1:0]  irq_clr;
      logic [IRQ_W-1:0]  irq_set;
      logic              wake;
      rd      = '0;
      miss    = 1'b0;
      clr     = '0;
      irq_clr = '0;
      irq_set = '0;
      wake    = 1'b0;
      next_r  = r;

      // Read decode, sampled in the setup cycle
      case (paddr)
         byte_addr(IDX_EN_RING):  rd[RING_BIT]    = r.en[RING_SRC];
         byte_addr(IDX_EN_G1):    rd[GRP_W-1:0]   = r.en[G1_LSB +: GRP_W];   // RQ4
         byte_addr(IDX_EN_G2):    rd[GRP_W-1:0]   = r.en[G2_LSB +: GRP_W];   // RQ5
         byte_addr(IDX_EN_G3):    rd[GRP_W-1:0]   = r.en[G3_LSB +: GRP_W];   // RQ6
         byte_addr(IDX_STS_G1):   rd[GRP_W-1:0]   = r.sts[G1_LSB +: GRP_W];
         byte_addr(IDX_STS_G2):   rd[GRP_W-1:0]   = r.sts[G2_LSB +: GRP_W];
         byte_addr(IDX_STS_G3):   rd[GRP_W-1:0]   = r.sts[G3_LSB +: GRP_W];
         byte_addr(IDX_STS_RING): rd[RING_BIT]    = r.sts[RING_SRC];
         byte_addr(IDX_CTRL):     rd[GEN_BIT]     = r.gen;
         byte_addr(IDX_IRQ_STS):  rd[IRQ_W-1:0]   = r.irq_sts;
         byte_addr(IDX_IRQ_CLR):  rd              = '0;
         byte_addr(IDX_IRQ_EN):   rd[IRQ_W-1:0]   = r.irq_en;
         default:                 miss            = 1'b1;
      endcase
      if (apb_setup)
      begin
         next_r.rdata = rd;
         next_r.err   = miss;
      end

      // Enable, control and status clear writes, taken in the access cycle
      if (apb_wr)
      begin
         if (reg_hit(paddr, IDX_EN_RING))
            next_r.en[RING_SRC] = pwdata[RING_BIT];
         if (reg_hit(paddr, IDX_EN_G1))
            next_r.en[G1_LSB +: GRP_W] = pwdata[GRP_W-1:0];   // RQ4
         if (reg_hit(paddr, IDX_EN_G2))
            next_r.en[G2_LSB +: GRP_W] = pwdata[GRP_W-1:0];   // RQ5
         if (reg_hit(paddr, IDX_EN_G3))
            next_r.en[G3_LSB +: GRP_W] = pwdata[GRP_W-1:0];   // RQ6
         if (reg_hit(paddr, IDX_CTRL))
            next_r.gen = pwdata[GEN_BIT];
         if (reg_hit(paddr, IDX_IRQ_EN))
            next_r.irq_en = pwdata[IRQ_W-1:0];
         if (reg_hit(paddr, IDX_IRQ_CLR))
            irq_clr = pwdata[IRQ_W-1:0];
         if (reg_hit(paddr, IDX_STS_G1))
            clr[G1_LSB +: GRP_W] = pwdata[GRP_W-1:0];         // RQ7
         if (reg_hit(paddr, IDX_STS_G2))
            clr[G2_LSB +: GRP_W] = pwdata[GRP_W-1:0];         // RQ7
         if (reg_hit(paddr, IDX_STS_G3))
            clr[G3_LSB +: GRP_W] = pwdata[GRP_W-1:0];         // RQ7
         if (reg_hit(paddr, IDX_STS_RING))
            clr[RING_SRC] = pwdata[RING_BIT];                 // RQ7
      end

      // Status: set by own event regardless of enables, set beats clear
      next_r.sts = (r.sts & ~clr) | src_bus.evt;               // RQ7 RQ8 RQ2

      // Wake combine: per-source AND, OR over all, global gate
      wake          = r.gen && (|(r.en & r.sts));               // RQ1 RQ9 RQ2
      next_r.wake_n = !wake;                                    // RQ1
      next_r.wake_q = wake;

      // Interrupt events: new wake assertion and bus error
      irq_set[IRQ_WAKE_BIT] = wake && !r.wake_q;
      irq_set[IRQ_ERR_BIT]  = apb_acc && r.err;
      next_r.irq_sts        = (r.irq_sts & ~irq_clr) | irq_set;

      // Host-side resets touch only the interrupt logic
      if (host_reset)
      begin
         next_r.irq_sts = IRQ_RST;
         next_r.irq_en  = IRQ_RST;
      end
   end

   // State register; only the standby power-on reset clears enables
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         r.en      <= EN_RST;                                    // RQ3
         r.sts     <= STS_RST;
         r.gen     <= GEN_RST;
         r.irq_sts <= IRQ_RST;
         r.irq_en  <= IRQ_RST;
         r.rdata   <= RD_RST;
         r.err     <= 1'b0;
         r.wake_n  <= 1'b1;
         r.wake_q  <= 1'b0;
      end
      else if (clk_en)
      begin
         r <= next_r;
      end
   end

   // Outputs
   assign pready        = clk_en;
   assign prdata        = r.rdata;
   assign pslverr       = r.err;
   assign wake_output_n = r.wake_n;
   assign irq           = |(r.irq_sts & r.irq_en);

   // Checks

   wake_drive_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
      clk_en && r.gen && (|(r.en & r.sts)) |=> !wake_output_n)
      else $error("wake output not driven for enabled pending source");

   masked_quiet_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
      clk_en && ((r.en & r.sts) == '0) |=> wake_output_n)
      else $error("wake output driven with no enabled pending source");

   global_gate_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ9
      clk_en && !r.gen ##1 clk_en && !r.gen |=> wake_output_n)
      else $error("wake output driven while global enable is off");

   status_set_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
      clk_en && (src_bus.evt != '0) |=> (r.sts & $past(src_bus.evt)) == $past(src_bus.evt))
      else $error("source event did not set its status bit");

   status_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
      clk_en && apb_wr && reg_hit(paddr, IDX_STS_G1) && (src_bus.evt == '0)
      |=> (r.sts[G1_LSB +: GRP_W] & $past(pwdata[GRP_W-1:0])) == '0)
      else $error("writing one did not clear a status bit");

   status_keep_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
      clk_en && apb_wr && reg_hit(paddr, IDX_STS_G2)
      |=> (($past(r.sts[G2_LSB +: GRP_W]) & ~$past(pwdata[GRP_W-1:0]))
           & ~r.sts[G2_LSB +: GRP_W]) == '0)
      else $error("writing zero changed a status bit");

   enable_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
      clk_en && host_reset && !apb_wr |=> r.en == $past(r.en))
      else $error("host reset disturbed the enable registers");

   group1_map_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
      clk_en && apb_wr && reg_hit(paddr, IDX_EN_G1)
      |=> r.en[G1_LSB +: GRP_W] == $past(pwdata[GRP_W-1:0]))
      else $error("first group enable write misplaced");

   group2_map_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
      clk_en && apb_wr && reg_hit(paddr, IDX_EN_G2)
      |=> r.en[G2_LSB +: GRP_W] == $past(pwdata[GRP_W-1:0]))
      else $error("second group enable write misplaced");

   group3_read_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
      clk_en && apb_setup && reg_hit(paddr, IDX_EN_G3)
      |=> prdata[GRP_W-1:0] == $past(r.en[G3_LSB +: GRP_W]))
      else $error("mixed group enable readback wrong");

   // Map, status clear, reset, bus, interrupt and clock enable checks

   group3_map_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
      clk_en && apb_wr && reg_hit(paddr, IDX_EN_G3)
      |=> r.en[G3_LSB +: GRP_W] == $past(pwdata[GRP_W-1:0]))
      else $error("mixed group enable write misplaced");

   ring_map_a: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && apb_wr && reg_hit(paddr, IDX_EN_RING)
      |=> r.en[RING_SRC] == $past(pwdata[RING_BIT]))
      else $error("ring indicate enable write misplaced");

   ring_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
      clk_en && apb_wr && reg_hit(paddr, IDX_STS_RING) && pwdata[RING_BIT]
      && !src_bus.evt[RING_SRC] |=> !r.sts[RING_SRC])
      else $error("writing one did not clear the ring status bit");

   host_keep_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
      clk_en && host_reset && !apb_wr |=> r.gen == $past(r.gen))
      else $error("host reset disturbed the global wake enable");

   host_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && host_reset |=> (r.irq_sts == '0) && (r.irq_en == '0))
      else $error("host reset left interrupt state behind");

   error_resp_a: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && apb_setup |=> pslverr == !addr_mapped($past(paddr)))
      else $error("error response disagrees with the address map");

   read_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && apb_setup && !addr_mapped(paddr) |=> prdata == '0)
      else $error("unmapped read returned nonzero data");

   error_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && apb_acc && pslverr && !host_reset |=> r.irq_sts[IRQ_ERR_BIT])
      else $error("bus error did not raise its interrupt status");

   wake_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && !host_reset && !r.wake_q && r.gen && (|(r.en & r.sts))
      |=> r.irq_sts[IRQ_WAKE_BIT])
      else $error("new wake assertion did not raise its interrupt status");

   freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
      !clk_en |=> r == $past(r))
      else $error("state changed while the clock enable was low");

endmodule : wge_bank

// ### hdl/wge_pkg.sv
// Shared constants and helpers for the wake enable gating bank.
// Assumes a 32-bit APB slave port with 12-bit byte addresses.
package wge_pkg;

   // Source vector layout: one bit per wake source
   localparam int           SRC_W         = 25;
   localparam int           G1_LSB        = 0;
   localparam int           G2_LSB        = 8;
   localparam int           G3_LSB        = 16;
   localparam int           RING_SRC      = 24;
   localparam int           GRP_W         = 8;

   // Bus geometry
   localparam int           ADDR_W        = 12;
   localparam int           DATA_W        = 32;

   // Register indices; byte address is four times the index
   localparam logic [7:0]   IDX_EN_RING   = 8'h0a;
   localparam logic [7:0]   IDX_EN_G1     = 8'h0b;
   localparam logic [7:0]   IDX_EN_G2     = 8'h0c;
   localparam logic [7:0]   IDX_EN_G3     = 8'h0d;
   localparam logic [7:0]   IDX_STS_G1    = 8'h20;
   localparam logic [7:0]   IDX_STS_G2    = 8'h21;
   localparam logic [7:0]   IDX_STS_G3    = 8'h22;
   localparam logic [7:0]   IDX_STS_RING  = 8'h23;
   localparam logic [7:0]   IDX_CTRL      = 8'h24;
   localparam logic [7:0]   IDX_IRQ_STS   = 8'h28;
   localparam logic [7:0]   IDX_IRQ_CLR   = 8'h29;
   localparam logic [7:0]   IDX_IRQ_EN    = 8'h2a;

   // Field positions
   localparam int           RING_BIT      = 7;
   localparam int           GEN_BIT       = 0;
   localparam int           IRQ_WAKE_BIT  = 0;
   localparam int           IRQ_ERR_BIT   = 1;
   localparam int           IRQ_W         = 2;

   // Reset values
   localparam logic [SRC_W-1:0] EN_RST    = 25'h0000000;
   localparam logic [SRC_W-1:0] STS_RST   = 25'h0000000;
   localparam logic             GEN_RST   = 1'b0;
   localparam logic [IRQ_W-1:0] IRQ_RST   = 2'h0;
   localparam logic [DATA_W-1:0] RD_RST   = 32'h00000000;

   // Byte address of a register index
   function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
      byte_addr = {2'h0, idx, 2'h0};
   endfunction : byte_addr

   // Address match against a register index
   function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
      reg_hit = (addr == byte_addr(idx));
   endfunction : reg_hit

endpackage : wge_pkg

// ### hdl/wge_src_if.sv
// Carries synchronised wake source levels and event pulses.
// Assumes both ends run on pclk.
`timescale 1ns/1ps
interface wge_src_if;
   import wge_pkg::*;
   logic [SRC_W-1:0] level;   // Synchronised active level per source
   logic [SRC_W-1:0] evt;     // One-cycle pulse on assertion

   modport producer (output level, output evt);
   modport consumer (input level, input evt);
endinterface : wge_src_if

// ### hdl/wge_pin_sync.sv
// Two-stage synchroniser and assertion detector for wake source pins.
// Assumes pins are asynchronous and already converted to active high.
`timescale 1ns/1ps
module wge_pin_sync
   import wge_pkg::*;
(
   // Clock and reset
   input  logic             pclk,
   input  logic             presetn,
   input  logic             clk_en,
   // Raw pins
   input  logic [SRC_W-1:0] pins,
   // Synchronised sources
   wge_src_if.producer      src
);

   typedef struct packed {
      logic [SRC_W-1:0] s1;
      logic [SRC_W-1:0] s2;
      logic [SRC_W-1:0] s3;
   } wge_sync_state_type;

   wge_sync_state_type r;
   wge_sync_state_type next_r;

   // Shift chain; first stage feeds only the second
   always_comb
   begin
      next_r    = r;
      next_r.s1 = pins;
      next_r.s2 = r.s1;
      next_r.s3 = r.s2;
   end

   // State register, frozen while clk_en is low
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         r <= '0;
      end
      else if (clk_en)
      begin
         r <= next_r;
      end
   end

   // Level and rising-edge event
   assign src.level = r.s2;
   assign src.evt   = r.s2 & ~r.s3;

   evt_single_a: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && (src.evt != '0) |=> (src.evt & $past(src.evt)) == '0)
      else $error("source event lasted more than one cycle");

endmodule : wge_pin_sync

// ### verification/wge_host_model.sv
// Host side of the wake line: counts each new wake assertion.
// Assumes the device drives wake_output_n from pclk flops.
`timescale 1ns/1ps
module wge_host_model
   import wge_pkg::*;
(
   // Clock and reset
   input  logic pclk,
   input  logic presetn,
   // Wake line from the device
   input  logic wake_output_n,
   // Observation
   output int   wake_count
);
   logic last_n;

   // Count falling edges of the active-low wake line
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         last_n     <= 1'b1;
         wake_count <= 0;
      end
      else
      begin
         last_n <= wake_output_n;
         if (last_n && !wake_output_n)
            wake_count <= wake_count + 1;
      end
   end
endmodule : wge_host_model

// ### verification/wge_bank_tb.sv
// Self-checking bench for the wake enable gating bank over APB.
// Assumes zero-wait APB answers and the source layout of wge_pkg.
`timescale 1ns/1ps
module wge_bank_tb;
   import wge_pkg::*;
   logic              pclk, presetn, clk_en, host_reset, psel, penable, pwrite;
   logic              pready, pslverr, wake_output_n, irq;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata, rd;
   logic [3:0]        pstrb;
   logic [SRC_W-1:0]  src;
   int                n_mismatch, checks_done, wake_count;

   // Clock at 200 MHz
   initial pclk = 1'b0;
   always #2.5 pclk = ~pclk;

   wge_bank dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .host_reset(host_reset),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .gpio_a(src[7:0]), .gpio_b(src[15:8]), .gpio_c(src[19:16]), .gpio_d1(src[20]),
      .gpio_d3(src[21]), .gpio_e0(src[22]), .gpio_e1(src[23]),
      .second_port_ring_indicate_n(~src[24]), .wake_output_n(wake_output_n), .irq(irq));

   wge_host_model host (.pclk(pclk), .presetn(presetn), .wake_output_n(wake_output_n),
      .wake_count(wake_count));

   task automatic stop_test();
      $display("Checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : stop_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // One APB transfer; waits for pready under a bound
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'h0, idx, 2'h0};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++)
      begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      if (i == 20)
      begin
         n_mismatch++;
         stop_test();
      end
      rd = prdata;
      chk({31'h0, pslverr}, {31'h0, (idx == 8'h3f)});
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0);
      chk(rd, exp);
   endtask : rdchk

   // Bounded wait for irq (sel=1) or the wake line (sel=0) to reach a level
   task automatic wait_for(input logic sel, input logic e);
      int i;
      for (i = 0; i < 30 && (sel ? irq : wake_output_n) !== e; i++)
         @(posedge pclk);
      chk({31'h0, (sel ? irq : wake_output_n)}, {31'h0, e});
   endtask : wait_for

   task automatic pulse(input int n);
      @(posedge pclk) src[n] <= 1'b1;
      repeat (4) @(posedge pclk);
      src[n] <= 1'b0;
      repeat (4) @(posedge pclk);
   endtask : pulse

   task automatic t_defaults();
      rdchk(8'h0b, 32'h0);
      rdchk(8'h0c, 32'h0);
      rdchk(8'h0d, 32'h0);
      chk({31'h0, wake_output_n}, 32'h1);
   endtask : t_defaults

   // Each source alone, through its own enable bit and status bit
   task automatic t_map();
      logic [7:0]  en_idx, st_idx;
      logic [31:0] m;
      apb(1'b1, 8'h24, 32'h1);
      for (int i = 0; i < SRC_W; i++)
      begin
         en_idx = (i == RING_SRC) ? 8'h0a : 8'h0b + 8'(i / 8);
         st_idx = (i == RING_SRC) ? 8'h23 : 8'h20 + 8'(i / 8);
         m = (i == RING_SRC) ? 32'h80 : 32'h1 << (i % 8);
         apb(1'b1, en_idx, m);
         pulse(i);
         wait_for(1'b0, 1'b0);
         rdchk(st_idx, m);
         apb(1'b1, st_idx, m);
         wait_for(1'b0, 1'b1);
         apb(1'b1, en_idx, 32'h0);
      end
      chk(32'(wake_count), 32'd25);
   endtask : t_map

   task automatic t_gating();
      pulse(3);
      repeat (8) @(posedge pclk);
      chk({31'h0, wake_output_n}, 32'h1);
      rdchk(8'h20, 32'h08);
      apb(1'b1, 8'h20, 32'hf7);
      rdchk(8'h20, 32'h08);
      apb(1'b1, 8'h0b, 32'h08);
      wait_for(1'b0, 1'b0);
      apb(1'b1, 8'h24, 32'h0);
      wait_for(1'b0, 1'b1);
      apb(1'b1, 8'h20, 32'h08);
      rdchk(8'h20, 32'h0);
   endtask : t_gating

   // Interrupt on a new wake; a bus error sets only its masked status bit, irq stays low; stale status cleared first
   task automatic t_irq();
      apb(1'b1, 8'h29, 32'h3);
      apb(1'b1, 8'h2a, 32'h1);
      apb(1'b1, 8'h0b, 32'h02);
      @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, 8'h24, 32'h1);
      pulse(1);
      wait_for(1'b0, 1'b0);
      wait_for(1'b1, 1'b1);
      rdchk(8'h28, 32'h1);
      apb(1'b1, 8'h29, 32'h1);
      wait_for(1'b1, 1'b0);
      rdchk(8'h3f, 32'h0);
      rdchk(8'h28, 32'h2);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, 8'h29, 32'h2);
      apb(1'b1, 8'h0b, 32'h0);
      apb(1'b1, 8'h20, 32'hff);
   endtask : t_irq

   // Clock enable low freezes the bank; the held pin is taken on resume
   task automatic t_freeze();
      apb(1'b1, 8'h0b, 32'h04);
      @(posedge pclk) clk_en <= 1'b0;
      src[2] <= 1'b1;
      repeat (6) @(posedge pclk);
      chk({31'h0, pready}, 32'h0);
      chk({31'h0, wake_output_n}, 32'h1);
      clk_en <= 1'b1;
      wait_for(1'b0, 1'b0);
      @(posedge pclk) src[2] <= 1'b0;
      rdchk(8'h20, 32'h04);
      apb(1'b1, 8'h20, 32'h04);
      apb(1'b1, 8'h0b, 32'h0);
      wait_for(1'b0, 1'b1);
   endtask : t_freeze

   // Enables survive host reset, clear on standby power-on reset
   task automatic t_resets();
      apb(1'b1, 8'h0b, 32'ha5);
      apb(1'b1, 8'h0c, 32'h5a);
      apb(1'b1, 8'h0d, 32'hc3);
      @(posedge pclk) host_reset <= 1'b1;
      @(posedge pclk) host_reset <= 1'b0;
      rdchk(8'h0b, 32'ha5);
      rdchk(8'h0c, 32'h5a);
      rdchk(8'h0d, 32'hc3);
      rdchk(8'h24, 32'h1);
      rdchk(8'h2a, 32'h0);
      @(posedge pclk) presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(8'h0b, 32'h0);
      rdchk(8'h0c, 32'h0);
      rdchk(8'h0d, 32'h0);
      rdchk(8'h24, 32'h0);
      chk({31'h0, wake_output_n}, 32'h1);
   endtask : t_resets

   // Main sequence
   initial
   begin
      {presetn, host_reset, psel, penable, pwrite} = 5'h0;
      clk_en = 1'b1;
      paddr = '0;
      pwdata = '0;
      pstrb = 4'h1;
      src = '0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_defaults();
      t_map();
      t_gating();
      t_irq();
      t_freeze();
      t_resets();
      stop_test();
   end
endmodule : wge_bank_tb
